/* File: src/tmr8_wave.v */
// 8-bit timer/counter with two compare channels and six waveform modes
// assumes i_tick is a one-cycle timer clock enable from an outside prescaler
// assumes mode fields are levels that software holds between writes
// assumes writes and flag clears are one-clock strobes
// limitation: a counter write does not block the next compare match
// the channel module keeps compare buffering and the output registers
//
// Overview of operation
// - mode zero counts up, wraps at max
// - normal mode flags overflow as count becomes zero
// - normal mode accepts counter writes any time
// - mode two clears counter on match A
// - ctc compare A unbuffered; below count wraps first
// - ctc output mode one toggles output A
// - ctc flags overflow passing max to zero
// - modes three, seven are fast pwm
// - fast pwm counts to top then clears
// - fast pwm clear/set on match and bottom
// - fast pwm flags overflow at top
// - fast pwm toggle A only with high bit
// - output reaches pin only when direction output
// - fast pwm extreme compare values give spike/constant
// - fast pwm compare values double buffered
// - modes one, five are phase-correct pwm
// - phase-correct holds top one tick, reverses
// - phase-correct clears up-match, sets down-match
// - phase-correct flags overflow at zero
// - phase-correct extremes give constant levels
// - phase-correct fixes output at top without match
// - phase-correct toggle A only with high bit
// - mode field low bits A, high bit B
// - pwm compare updates at top only
// - nonzero output mode overrides port value
// - clock select zero stops counter
`timescale 1ns/10ps
`include "tmr8_regs.vh"
module tmr8_wave (
    input wire i_mclk,
    input wire i_rst_n,
    input wire i_tick,
    input wire [2:0] i_clock_select_field,
    input wire [1:0] i_waveform_mode_low,
    input wire i_waveform_mode_high_bit,
    input wire [1:0] i_output_mode_a,
    input wire [1:0] i_output_mode_b,
    input wire i_counter_wr,
    input wire [7:0] i_counter_wdata,
    input wire i_cmp_a_wr,
    input wire [7:0] i_cmp_a_wdata,
    input wire i_cmp_b_wr,
    input wire [7:0] i_cmp_b_wdata,
    input wire i_overflow_clr,
    input wire i_compare_flag_a_clr,
    input wire i_compare_flag_b_clr,
    input wire i_pin_dir_a,
    input wire i_pin_dir_b,
    input wire i_port_val_a,
    input wire i_port_val_b,
    output reg [7:0] o_counter_value,
    output wire [7:0] o_compare_value_a,
    output wire [7:0] o_compare_value_b,
    output reg o_overflow_flag,
    output reg o_compare_flag_a,
    output reg o_compare_flag_b,
    output reg o_count_down,
    output wire o_wave_out_a,
    output wire o_wave_out_b,
    output wire o_pin_a_val,
    output wire o_pin_a_oe,
    output wire o_pin_b_val,
    output wire o_pin_b_oe
);
    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    // mode classes are one-hot, though each class test compares all four bits
    localparam [3:0] ST_NORMAL = 4'h1;
    localparam [3:0] ST_CTC = 4'h2;
    localparam [3:0] ST_FAST = 4'h4;
    localparam [3:0] ST_PHASE = 4'h8;

    // decoded mode
    wire [2:0] waveform_mode_field;
    wire [3:0] mode_cls;
    wire fast_mode;
    wire phase_mode;
    wire pwm;
    wire top_is_a;

    // counting limits and channel results
    wire run;
    wire [7:0] top;
    wire [7:0] cmp_a_act;
    wire match_a;
    wire match_b;

    // end points and the strobes built on them
    wire at_top;
    wire at_bottom;
    wire bottom_next;
    wire upd;

    // next values of the counter and flag registers
    reg [7:0] count_next;
    reg dir_next;
    reg ovf_next;
    reg ocfa_next;
    reg ocfb_next;

    // one decoder serves both the counter and the compare channels
    function [3:0] tmr8_mode_class;
        input [2:0] wgm;
        begin
            // codes four and six are not defined and fall into normal
            case (wgm)
                `TMR8_WGM_CTC: tmr8_mode_class = ST_CTC;
                `TMR8_WGM_FAST_FIX: tmr8_mode_class = ST_FAST;
                `TMR8_WGM_FAST_OCRA: tmr8_mode_class = ST_FAST;
                `TMR8_WGM_PC_FIX: tmr8_mode_class = ST_PHASE;
                `TMR8_WGM_PC_OCRA: tmr8_mode_class = ST_PHASE;
                default: tmr8_mode_class = ST_NORMAL;
            endcase
        end
    endfunction

    // the high mode bit comes from a different control field than the low pair
    assign waveform_mode_field = {i_waveform_mode_high_bit, i_waveform_mode_low};
    assign mode_cls = tmr8_mode_class(waveform_mode_field);
    assign fast_mode = (mode_cls == ST_FAST);
    assign phase_mode = (mode_cls == ST_PHASE);
    assign pwm = fast_mode || phase_mode;

    // modes five and seven take their turning point from compare a
    assign top_is_a = (waveform_mode_field == `TMR8_WGM_FAST_OCRA) ||
                      (waveform_mode_field == `TMR8_WGM_PC_OCRA);
    assign top = top_is_a ? cmp_a_act : `TMR8_MAX;

    // a stopped clock select swallows ticks, software writes still land
    assign run = i_tick && (i_clock_select_field != `TMR8_CS_STOP);

    // end points of the counting range, from the present count
    assign at_top = (o_counter_value == top);
    assign at_bottom = (o_counter_value == `TMR8_BOTTOM);

    // fast pwm wraps from top to bottom on the next tick
    assign bottom_next = run && fast_mode && at_top;
    // both pwm kinds load at the top tick: fast starts its next period
    // at bottom with the new value, phase correct turns round with it
    assign upd = run && pwm && at_top;

    // ------------------------------------------------------------
    // counter and flags
    // ------------------------------------------------------------
    // a software write to the counter beats every count or clear
    always @* begin
        count_next = o_counter_value;
        dir_next = o_count_down;
        ovf_next = o_overflow_flag;
        ocfa_next = o_compare_flag_a;
        ocfb_next = o_compare_flag_b;

        // clears come first, so a set later in this block wins the cycle
        if (i_overflow_clr) begin
            ovf_next = 1'b0;
        end

        if (i_compare_flag_a_clr) begin
            ocfa_next = 1'b0;
        end

        if (i_compare_flag_b_clr) begin
            ocfb_next = 1'b0;
        end

        // every counting decision waits for a tick
        if (run) begin
            // a match on the active value sets its flag
            if (match_a) begin
                ocfa_next = 1'b1;
            end
            if (match_b) begin
                ocfb_next = 1'b1;
            end

            // counting sequence of the selected class
            case (mode_cls)
                ST_CTC: begin
                    // compare a is the top: a match clears instead of counting
                    // a top written below the count is missed until the wrap
                    if (match_a) begin
                        count_next = `TMR8_BOTTOM;
                    end else begin
                        count_next = o_counter_value + `TMR8_ONE;
                    end

                    // overflow only when the count itself passes max
                    if (o_counter_value == `TMR8_MAX) begin
                        ovf_next = 1'b1;
                    end
                    // only phase correct ever counts down
                    dir_next = 1'b0;
                end

                ST_FAST: begin
                    // top lasts one tick, and the tick after it is bottom
                    if (at_top) begin
                        count_next = `TMR8_BOTTOM;
                        ovf_next = 1'b1;
                    end else begin
                        count_next = o_counter_value + `TMR8_ONE;
                    end
                    dir_next = 1'b0;
                end

                ST_PHASE: begin
                    // top and bottom each last exactly one tick before reversing
                    if (!o_count_down) begin
                        // up slope
                        if (at_top) begin
                            dir_next = 1'b1;
                            count_next = o_counter_value - `TMR8_ONE;
                        end else begin
                            count_next = o_counter_value + `TMR8_ONE;
                        end
                    end else begin
                        // down slope
                        if (at_bottom) begin
                            dir_next = 1'b0;
                            count_next = o_counter_value + `TMR8_ONE;
                        end else begin
                            count_next = o_counter_value - `TMR8_ONE;
                        end
                    end

                    // overflow on the tick that brings the count down to zero
                    if (o_count_down && o_counter_value == `TMR8_ONE) begin
                        ovf_next = 1'b1;
                    end
                end

                default: begin
                    // normal mode, and the undefined codes four and six
                    count_next = o_counter_value + `TMR8_ONE;
                    if (o_counter_value == `TMR8_MAX) begin
                        ovf_next = 1'b1;
                    end
                    dir_next = 1'b0;
                end
            endcase
        end

        // taken with or without a tick
        if (i_counter_wr) begin
            count_next = i_counter_wdata;
        end
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    // reset is synchronous: every register returns to zero at a clock edge
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_counter_value <= `TMR8_BOTTOM;
            o_count_down <= 1'b0;
            o_overflow_flag <= 1'b0;
            o_compare_flag_a <= 1'b0;
            o_compare_flag_b <= 1'b0;
        end else begin
            // every register simply takes its next value
            o_counter_value <= count_next;
            o_count_down <= dir_next;
            o_overflow_flag <= ovf_next;
            o_compare_flag_a <= ocfa_next;
            o_compare_flag_b <= ocfb_next;
        end
    end

    // ------------------------------------------------------------
    // compare channels
    // ------------------------------------------------------------
    // toggle in pwm is offered on channel a only, and only with the high mode bit
    // both channels share the counter, its direction and the update strobe
    tmr8_wave_chan u_chan_a (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_tick(run),
        .i_pwm(pwm),
        .i_fast(fast_mode),
        .i_toggle_ok(i_waveform_mode_high_bit),
        // channel settings
        .i_out_mode(i_output_mode_a),
        .i_count(o_counter_value),
        .i_top(top),
        .i_up(~o_count_down),
        .i_upd(upd),
        .i_bottom_next(bottom_next),
        // compare value written by software
        .i_cmp_wr(i_cmp_a_wr),
        .i_cmp_wdata(i_cmp_a_wdata),
        // pin side
        .i_pin_dir(i_pin_dir_a),
        .i_port_val(i_port_val_a),
        // results
        .o_cmp_active(cmp_a_act),
        .o_cmp_buf(o_compare_value_a),
        .o_match(match_a),
        .o_wave(o_wave_out_a),
        .o_pin_val(o_pin_a_val),
        .o_pin_oe(o_pin_a_oe)
    );

    // channel b never sets the top, so its active value stays inside
    tmr8_wave_chan u_chan_b (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_tick(run),
        .i_pwm(pwm),
        .i_fast(fast_mode),
        .i_toggle_ok(1'b0),
        // channel settings
        .i_out_mode(i_output_mode_b),
        .i_count(o_counter_value),
        .i_top(top),
        .i_up(~o_count_down),
        .i_upd(upd),
        .i_bottom_next(bottom_next),
        // compare value written by software
        .i_cmp_wr(i_cmp_b_wr),
        .i_cmp_wdata(i_cmp_b_wdata),
        // pin side
        .i_pin_dir(i_pin_dir_b),
        .i_port_val(i_port_val_b),
        // results
        .o_cmp_active(),
        .o_cmp_buf(o_compare_value_b),
        .o_match(match_b),
        .o_wave(o_wave_out_b),
        .o_pin_val(o_pin_b_val),
        .o_pin_oe(o_pin_b_oe)
    );
endmodule // tmr8_wave

/* File: src/tmr8_regs.vh */
// constants for the 8-bit timer waveform block: modes, output modes, counter limits
// assumes inclusion by bare name from the design files
`ifndef TMR8_REGS_VH
`define TMR8_REGS_VH
`define TMR8_W 8
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hff
`define TMR8_ONE 8'h01
`define TMR8_WGM_NORMAL 3'h0
`define TMR8_WGM_PC_FIX 3'h1
`define TMR8_WGM_CTC 3'h2
`define TMR8_WGM_FAST_FIX 3'h3
`define TMR8_WGM_PC_OCRA 3'h5
`define TMR8_WGM_FAST_OCRA 3'h7
`define TMR8_COM_OFF 2'h0
`define TMR8_COM_TOGGLE 2'h1
`define TMR8_COM_CLEAR 2'h2
`define TMR8_COM_SET 2'h3
`define TMR8_CS_STOP 3'h0
`endif

/* File: src/tmr8_wave_chan.v */
// one compare channel: buffered compare value, match detect, output register
// assumes the parent supplies counter state, mode class and timer tick
`timescale 1ns/10ps
`include "tmr8_regs.vh"
module tmr8_wave_chan (
    input wire i_mclk,
    input wire i_rst_n,
    input wire i_tick,
    input wire i_pwm,
    input wire i_fast,
    input wire i_toggle_ok,
    input wire [1:0] i_out_mode,
    input wire [7:0] i_count,
    input wire [7:0] i_top,
    input wire i_up,
    input wire i_upd,
    input wire i_bottom_next,
    input wire i_cmp_wr,
    input wire [7:0] i_cmp_wdata,
    input wire i_pin_dir,
    input wire i_port_val,
    output reg [7:0] o_cmp_active,
    output reg [7:0] o_cmp_buf,
    output wire o_match,
    output reg o_wave,
    output wire o_pin_val,
    output wire o_pin_oe
);
    reg [7:0] cmp_active_next;
    reg [7:0] cmp_buf_next;
    reg wave_next;

    assign o_match = (i_count == o_cmp_active);

    // ------------------------------------------------------------
    // compare value buffering
    // ------------------------------------------------------------
    // pwm writes land in the buffer and reach the comparator only on the tick at top
    always @* begin
        cmp_buf_next = o_cmp_buf;
        cmp_active_next = o_cmp_active;
        if (i_cmp_wr) begin
            cmp_buf_next = i_cmp_wdata;
        end
        if (!i_pwm) begin
            if (i_cmp_wr) begin
                cmp_active_next = i_cmp_wdata;
            end
        end else if (i_upd) begin
            cmp_active_next = cmp_buf_next;
        end
    end

    // ------------------------------------------------------------
    // waveform output register
    // ------------------------------------------------------------
    always @* begin
        wave_next = o_wave;
        if (i_tick && i_out_mode != `TMR8_COM_OFF) begin
            if (!i_pwm) begin
                if (o_match) begin
                    case (i_out_mode)
                        `TMR8_COM_TOGGLE: wave_next = ~o_wave;
                        `TMR8_COM_CLEAR: wave_next = 1'b0;
                        default: wave_next = 1'b1;
                    endcase
                end
            end else if (i_out_mode == `TMR8_COM_TOGGLE) begin
                if (i_toggle_ok && o_match) begin
                    wave_next = ~o_wave;
                end
            end else if (i_fast) begin
                // match at top is ignored so top gives a constant level
                if (i_bottom_next) begin
                    wave_next = ~i_out_mode[0];
                end else if (o_match && o_cmp_active != i_top) begin
                    wave_next = i_out_mode[0];
                end
            end else begin
                if (i_count == i_top) begin
                    // level at top is the up-count match result, or its inverse when compare equals top
                    wave_next = (o_cmp_active == i_top) ? ~i_out_mode[0]
                                                        : i_out_mode[0];
                end else if (o_match) begin
                    // a match at bottom acts as up-counting, so a zero compare stays flat
                    wave_next = (i_up || i_count == `TMR8_BOTTOM) ? i_out_mode[0]
                        : ~i_out_mode[0];
                end
            end
        end
    end

    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_cmp_active <= `TMR8_BOTTOM;
            o_cmp_buf <= `TMR8_BOTTOM;
            o_wave <= 1'b0;
        end else begin
            o_cmp_active <= cmp_active_next;
            o_cmp_buf <= cmp_buf_next;
            o_wave <= wave_next;
        end
    end

    // the pin carries the wave only while the mode is on and direction is output
    assign o_pin_val = (i_out_mode != `TMR8_COM_OFF) ? o_wave : i_port_val;
    assign o_pin_oe = i_pin_dir;
endmodule // tmr8_wave_chan

/* File: tb/tmr8_pin_load.sv */
// far-side load on the two timer pins: a pulled-up line per pin
// assumes the block drives a pin only while its output enable is high
`timescale 1ns/10ps
module tmr8_pin_load (
    input wire i_val_a,
    input wire i_oe_a,
    input wire i_val_b,
    input wire i_oe_b,
    output wire o_level_a,
    output wire o_level_b
);
    // a released pin floats up through the pull-up instead of keeping its last level
    assign o_level_a = i_oe_a ? i_val_a : 1'b1;
    assign o_level_b = i_oe_b ? i_val_b : 1'b1;
endmodule // tmr8_pin_load

/* File: tb/tmr8_wave_checker.sv */
// port-level checker for the 8-bit timer waveform block
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/10ps
module tmr8_wave_checker (
    input wire i_mclk,
    input wire i_rst_n,
    input wire i_tick,
    input wire [2:0] i_clock_select_field,
    input wire [1:0] i_waveform_mode_low,
    input wire i_waveform_mode_high_bit,
    input wire [1:0] i_output_mode_a,
    input wire i_counter_wr,
    input wire [7:0] i_counter_wdata,
    input wire i_cmp_a_wr,
    input wire i_pin_dir_a,
    input wire i_port_val_a,
    input wire [7:0] o_counter_value,
    input wire [7:0] o_compare_value_a,
    input wire o_overflow_flag,
    input wire o_count_down,
    input wire o_wave_out_a,
    input wire o_pin_a_val,
    input wire o_pin_a_oe
);
    // a counting tick that no counter write overrides
    wire [2:0] md = {i_waveform_mode_high_bit, i_waveform_mode_low};
    wire go = i_tick && (i_clock_select_field != 3'h0) && !i_counter_wr;
    wire [7:0] cnt = o_counter_value;
    wire ctc_hit = go && (md == 3'h2) && !i_cmp_a_wr && (cnt == o_compare_value_a);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    norm_wrap_a: assert property (go && md == 3'h0 && cnt == 8'hff |=> cnt == 8'h00 && o_overflow_flag)
        else $error("normal wrap wrong");
    norm_step_a: assert property (go && (md == 3'h0 || md == 3'h4 || md == 3'h6) |=> cnt == $past(cnt) + 8'h01)
        else $error("normal step wrong");
    load_wins_a: assert property (i_counter_wr |=> cnt == $past(i_counter_wdata))
        else $error("counter load lost");
    stop_hold_a: assert property (i_clock_select_field == 3'h0 && !i_counter_wr |=> $stable(cnt))
        else $error("stopped counter moved");
    ctc_clear_a: assert property (ctc_hit |=> cnt == 8'h00)
        else $error("ctc clear missing");
    ctc_toggle_a: assert property (ctc_hit && i_output_mode_a == 2'h1 |=> o_wave_out_a != $past(o_wave_out_a))
        else $error("ctc toggle missing");
    fast_top_a: assert property (go && md == 3'h3 && cnt == 8'hff |=> cnt == 8'h00 && o_overflow_flag)
        else $error("fast top wrong");
    fast_set_a: assert property (go && md == 3'h3 && i_output_mode_a == 2'h2 && cnt == 8'hff |=> o_wave_out_a)
        else $error("fast bottom set missing");
    pc_turn_a: assert property (go && md == 3'h1 && cnt == 8'hff |=> o_count_down && cnt == 8'hfe)
        else $error("phase turn wrong");
    pc_bottom_a: assert property (go && md == 3'h1 && o_count_down && cnt == 8'h01 |=> cnt == 8'h00 && o_overflow_flag)
        else $error("phase bottom wrong");
    pin_mux_a: assert property (o_pin_a_oe == i_pin_dir_a && o_pin_a_val == (i_output_mode_a != 2'h0 ? o_wave_out_a : i_port_val_a))
        else $error("pin a source wrong");
endmodule // tmr8_wave_checker
bind tmr8_wave tmr8_wave_checker chk (.i_mclk, .i_rst_n, .i_tick, .i_clock_select_field,
    .i_waveform_mode_low, .i_waveform_mode_high_bit, .i_output_mode_a, .i_counter_wr,
    .i_counter_wdata, .i_cmp_a_wr, .i_pin_dir_a, .i_port_val_a, .o_counter_value,
    .o_compare_value_a, .o_overflow_flag, .o_count_down, .o_wave_out_a, .o_pin_a_val, .o_pin_a_oe);

/* File: tb/tmr8_wave_test.sv */
// self-checking bench for the 8-bit timer waveform block and its pin load
// assumes inputs change on the falling edge; one tick is one timer clock
`timescale 1ns/10ps
module tmr8_wave_test;
    reg clk, rst_n, tick, cwr, awr, bwr, ovc, fac, fbc, da, db, pa, pb, wh;
    reg [2:0] cs;
    reg [1:0] wl, oma, omb;
    reg [7:0] cwd, awd, bwd;
    wire [7:0] cnt, cva, cvb;
    wire ovf, cfa, cfb, dn, wa, wb, pva, poa, pvb, pob, la, lb;
    integer err_total, num_checks, k, bad;
    reg w0;
    tmr8_wave dut (.i_mclk(clk), .i_rst_n(rst_n), .i_tick(tick), .i_clock_select_field(cs),
        .i_waveform_mode_low(wl), .i_waveform_mode_high_bit(wh), .i_output_mode_a(oma),
        .i_output_mode_b(omb), .i_counter_wr(cwr), .i_counter_wdata(cwd), .i_cmp_a_wr(awr),
        .i_cmp_a_wdata(awd), .i_cmp_b_wr(bwr), .i_cmp_b_wdata(bwd), .i_overflow_clr(ovc),
        .i_compare_flag_a_clr(fac), .i_compare_flag_b_clr(fbc), .i_pin_dir_a(da),
        .i_pin_dir_b(db), .i_port_val_a(pa), .i_port_val_b(pb), .o_counter_value(cnt),
        .o_compare_value_a(cva), .o_compare_value_b(cvb), .o_overflow_flag(ovf),
        .o_compare_flag_a(cfa), .o_compare_flag_b(cfb), .o_count_down(dn), .o_wave_out_a(wa),
        .o_wave_out_b(wb), .o_pin_a_val(pva), .o_pin_a_oe(poa), .o_pin_b_val(pvb),
        .o_pin_b_oe(pob));
    tmr8_pin_load load_model (.i_val_a(pva), .i_oe_a(poa), .i_val_b(pvb), .i_oe_b(pob),
        .o_level_a(la), .o_level_b(lb));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task check(input [7:0] got, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("wrong value at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    // n timer ticks, each a one-cycle pulse with a quiet cycle after it
    task step(input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(negedge clk) tick = 1'b1;
                @(negedge clk) tick = 1'b0;
            end
        end
    endtask
    task load(input [7:0] v);
        begin
            @(negedge clk) cwr = 1'b1;
            cwd = v;
            @(negedge clk) cwr = 1'b0;
        end
    endtask
    task wcmp(input [7:0] a, input [7:0] b);
        begin
            @(negedge clk) awr = 1'b1;
            bwr = 1'b1;
            awd = a;
            bwd = b;
            @(negedge clk) awr = 1'b0;
            bwr = 1'b0;
        end
    endtask
    // clear all three sticky flags together
    task clr;
        begin
            @(negedge clk) {ovc, fac, fbc} = 3'h7;
            @(negedge clk) {ovc, fac, fbc} = 3'h0;
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d, mismatches %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_normal;
        begin
            check(cnt, 8'h00);
            for (k = 0; k < 3; k = k + 1) begin
                {wh, wl} = (k == 0) ? 3'h0 : ((k == 1) ? 3'h4 : 3'h6);
                load(8'hfe);
                clr;
                step(1);
                check(cnt, 8'hff);
                step(1);
                check(cnt, 8'h00);
                check(ovf, 1'b1);
            end
            cs = 3'h0;
            load(8'h5a);
            step(2);
            check(cnt, 8'h5a);
            cs = 3'h1;
            $display("normal and stop test done");
        end
    endtask
    task t_ctc;
        begin
            {wh, wl} = 3'h2;
            oma = 2'h1;
            wcmp(8'h03, 8'h00);
            load(8'h00);
            clr;
            w0 = wa;
            step(4);
            check(cnt, 8'h00);
            check(wa, !w0);
            check(cfa, 1'b1);
            check(cfb, 1'b1);
            load(8'h10);
            wcmp(8'h05, 8'h00);
            step(1);
            check(cnt, 8'h11);
            load(8'hff);
            clr;
            step(1);
            check(cnt, 8'h00);
            check(ovf, 1'b1);
            $display("ctc test done");
        end
    endtask
    task t_fast;
        begin
            {wh, wl} = 3'h3;
            oma = 2'h2;
            omb = 2'h3;
            wcmp(8'h80, 8'h80);
            load(8'hfe);
            clr;
            step(2);
            check(cnt, 8'h00);
            check(ovf, 1'b1);
            check({wa, wb}, 2'h2);
            wcmp(8'h05, 8'h05);
            check(cva, 8'h05);
            check(cvb, 8'h05);
            load(8'h05);
            step(1);
            check(wa, 1'b1);
            load(8'h80);
            step(1);
            check({wa, wb}, 2'h1);
            wcmp(8'hff, 8'hff);
            load(8'hfe);
            step(2);
            bad = 0;
            for (k = 0; k < 256; k = k + 1) begin
                step(1);
                if (wa !== 1'b1)
                    bad = 1;
            end
            check(bad, 0);
            $display("fast pwm test done");
        end
    endtask
    task t_phase;
        begin
            {wh, wl} = 3'h1;
            wcmp(8'h40, 8'h40);
            load(8'hfd);
            step(3);
            check(cnt, 8'hfe);
            check(dn, 1'b1);
            load(8'h40);
            step(1);
            check(wa, 1'b1);
            load(8'h02);
            clr;
            step(2);
            check(cnt, 8'h00);
            check(ovf, 1'b1);
            step(1);
            load(8'h40);
            step(1);
            check(wa, 1'b0);
            $display("phase pwm test done");
        end
    endtask
    // pin level as the external load sees it
    task t_pins;
        begin
            oma = 2'h0;
            da = 1'b0;
            pa = 1'b0;
            @(negedge clk);
            check(la, 1'b1);
            check(lb, 1'b1);
            da = 1'b1;
            @(negedge clk);
            check(la, 1'b0);
            pa = 1'b1;
            oma = 2'h2;
            @(negedge clk);
            check(la, 1'b0);
            $display("pin test done");
        end
    endtask
    // ----------------------------------------
    // clock, watchdog, main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // the whole run takes about 650 cycles; allow more than seven times that
    initial begin
        #50000;
        err_total = err_total + 1;
        finish_test;
    end
    initial begin
        err_total = 0;
        num_checks = 0;
        {rst_n, tick, cwr, awr, bwr, ovc, fac, fbc, da, db, pa, pb, wh} = 13'h0;
        {wl, oma, omb, cwd, awd, bwd} = 30'h0;
        cs = 3'h1;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        t_normal;
        t_ctc;
        t_fast;
        t_phase;
        t_pins;
        finish_test;
    end
endmodule // tmr8_wave_test
